// ### common/vpwifr_cfg.svh
`ifndef VPWIFR_CFG_SVH
`define VPWIFR_CFG_SVH

// Register byte offsets on the APB
`define VPWIFR_OFS_CTRL 12'h000
`define VPWIFR_OFS_DATA 12'h004
`define VPWIFR_OFS_STAT 12'h008

// Control register fields
`define VPWIFR_CTRL_NOCRC 0
`define VPWIFR_CTRL_CRC 1
`define VPWIFR_CTRL_SINGLE 2
`define VPWIFR_CTRL_NORM_BIT_FORMAT_SEL 3
`define VPWIFR_CTRL_TX_END_OF_DATA 4

// Status register fields
`define VPWIFR_STAT_TX_HOLDING_EMPTY 0
`define VPWIFR_STAT_ARB 1
`define VPWIFR_STAT_UNDR 2
`define VPWIFR_STAT_BERR 3
`define VPWIFR_STAT_STATE 4

// Reset values
`define VPWIFR_REQ_RST 3'h0
`define VPWIFR_DATA_RST 8'h00
`define VPWIFR_CNT_RST 3'h0

// Byte framing and check byte
`define VPWIFR_LAST_BIT 3'h7
`define VPWIFR_CRC_INIT 8'hff
`define VPWIFR_CRC_POLY 8'h1d

`endif

// ### common/vpwifr_pkg.sv
package vpwifr_pkg;

  typedef enum logic [3:0] {
    vpwifr_st_idle,
    vpwifr_st_norm,
    vpwifr_st_data,
    vpwifr_st_crc,
    vpwifr_st_eod,
    vpwifr_st_echo,
    vpwifr_st_extra,
    vpwifr_st_retry
  } vpwifr_state_t;

  typedef enum logic [1:0] {
    vpwifr_sym_norm,
    vpwifr_sym_data,
    vpwifr_sym_eod
  } vpwifr_sym_t;

endpackage : vpwifr_pkg

// ### hw/vpwifr_crc8.sv
`include "vpwifr_cfg.svh"

module vpwifr_crc8 (
  input wire logic mclk,          // Module clock
  input wire logic nrst,          // Synchronous reset, active low
  input wire logic clr,           // Restart the check sum
  input wire logic en,            // Feed one transmitted bit
  input wire logic din,           // Bit being fed
  output logic [7:0] crc_o        // Inverted check byte, including a bit fed now
);
  logic [7:0] crc_q;
  wire fb = crc_q[7] ^ din;
  wire [7:0] nxt = {crc_q[6:0], 1'b0} ^ (fb ? `VPWIFR_CRC_POLY : 8'h00);

  // Lets the caller load the check byte in the cycle of the final data bit
  assign crc_o = ~(en ? nxt : crc_q);

  always_ff @(posedge mclk) begin
    if (!nrst || clr) begin
      crc_q <= `VPWIFR_CRC_INIT;
    end else if (en) begin
      crc_q <= nxt;
    end
  end
endmodule : vpwifr_crc8

// ### hw/vpwifr_shift.sv
`include "vpwifr_cfg.svh"

module vpwifr_shift (
  input wire logic mclk,          // Module clock
  input wire logic nrst,          // Synchronous reset, active low
  input wire logic load,          // Load a new byte
  input wire logic [7:0] din,     // Byte to load
  input wire logic shift,         // Advance to the next bit
  output logic bit_o,             // Bit now on offer, msb first
  output logic last_o             // Bit on offer is the eighth
);
  logic [7:0] sh_q;
  logic [2:0] cnt_q;

  assign bit_o = sh_q[7];
  assign last_o = (cnt_q == `VPWIFR_LAST_BIT);

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      sh_q <= `VPWIFR_DATA_RST;
      cnt_q <= `VPWIFR_CNT_RST;
    end else if (load) begin
      sh_q <= din;
      cnt_q <= `VPWIFR_CNT_RST;
    end else if (shift) begin
      sh_q <= {sh_q[6:0], 1'b0};
      cnt_q <= cnt_q + 3'h1;
    end
  end
endmodule : vpwifr_shift

// ### hw/vpwifr_tx.sv
`include "vpwifr_cfg.svh"

module vpwifr_tx
  import vpwifr_pkg::*;
(
  input wire logic mclk,                      // Module clock, 25 MHz
  input wire logic nrst,                      // Synchronous reset, active low
  input wire logic psel,                      // APB select
  input wire logic penable,                   // APB access phase
  input wire logic pwrite,                    // APB write
  input wire logic [11:0] paddr,              // APB byte address
  input wire logic [31:0] pwdata,             // APB write data
  output logic [31:0] prdata,                 // APB read data
  output logic pready,                        // APB ready
  output logic pslverr,                       // APB error on unmapped address
  input wire logic rx_eod_ok,                 // Valid EOD received, no CRC error
  input wire logic rx_eof,                    // End of frame received
  input wire logic rx_byte_valid,             // A byte finished on the bus
  input wire logic [7:0] rx_byte,             // That byte
  input wire logic bus_error,                 // Bus error detected
  output logic sym_valid,                     // Symbol on offer
  output vpwifr_pkg::vpwifr_sym_t sym_kind,   // Kind of symbol on offer
  output logic sym_bit,                       // Bit value for norm and data symbols
  input wire logic sym_done,                  // Offered symbol has ended
  input wire logic sym_lost                   // Arbitration lost on that symbol
);
  import vpwifr_pkg::*;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  vpwifr_state_t state_q, state_d;
  logic [2:0] req_q, req_d;
  logic norm_bit_format_sel_q, tx_end_of_data_q, tx_end_of_data_d;
  logic [7:0] data_q, own_q;
  logic hold_q, tx_holding_empty_q, arb_q, undr_q, berr_q;
  logic post_eod_q, single_q, crc_q, extra_q, extra_d;
  logic [31:0] prdata_q;
  logic load_sh, sh_shift, crc_en, crc_clr, req_clr, tx_end_of_data_clr, take_hold;
  logic set_tx_holding_empty, set_arb, set_undr;
  logic [7:0] sh_din;
  logic sh_bit, sh_last;
  logic [7:0] crc_byte;

  // Bus slave decode
  wire setup = psel & ~penable;
  wire acc = psel & penable;
  wire hit_ctrl = hit(paddr, `VPWIFR_OFS_CTRL);
  wire hit_data = hit(paddr, `VPWIFR_OFS_DATA);
  wire hit_stat = hit(paddr, `VPWIFR_OFS_STAT);
  wire mapped = hit_ctrl | hit_data | hit_stat;
  wire wr_ctrl = acc & pwrite & hit_ctrl;
  wire wr_data = acc & pwrite & hit_data;
  wire wr_stat = acc & pwrite & hit_stat;
  assign pready = 1'b1;
  assign pslverr = acc & ~mapped;
  assign prdata = prdata_q;

  wire [31:0] rd_ctrl = {27'h0, tx_end_of_data_q, norm_bit_format_sel_q, req_q};
  wire [31:0] rd_data = {24'h0, data_q};
  wire [31:0] rd_stat = {24'h0, state_q, berr_q, undr_q, arb_q, tx_holding_empty_q};
  wire [31:0] rd_mux = hit_ctrl ? rd_ctrl : hit_data ? rd_data : hit_stat ? rd_stat : 32'h0;

  // Priority encode of the requests; raw bits are what software reads back
  wire eff_single = req_q[2];
  wire eff_crc = req_q[1] & ~req_q[2];
  wire eff_nocrc = req_q[0] & ~req_q[1] & ~req_q[2];
  wire any_req = eff_single | eff_crc | eff_nocrc;

  // A write landing once the EOD is in cannot arm a response
  wire late_wr = (post_eod_q | rx_eod_ok) & (state_q == vpwifr_st_idle);
  wire [2:0] wr_req = pwdata[2:0] & {3{~late_wr}};
  wire nb_val = crc_q ^ norm_bit_format_sel_q;

  assign sym_valid = (state_q == vpwifr_st_norm) | (state_q == vpwifr_st_data) |
                     (state_q == vpwifr_st_crc) | (state_q == vpwifr_st_eod) |
                     (state_q == vpwifr_st_extra);
  assign sym_kind = (state_q == vpwifr_st_norm) ? vpwifr_sym_norm :
                    (state_q == vpwifr_st_eod) ? vpwifr_sym_eod : vpwifr_sym_data;
  assign sym_bit = (state_q == vpwifr_st_norm) ? nb_val :
                   (state_q == vpwifr_st_extra) ? 1'b1 : sh_bit;

  vpwifr_shift u_shift (
    .mclk(mclk),
    .nrst(nrst),
    .load(load_sh),
    .din(sh_din),
    .shift(sh_shift),
    .bit_o(sh_bit),
    .last_o(sh_last)
  );

  vpwifr_crc8 u_crc (
    .mclk(mclk),
    .nrst(nrst),
    .clr(crc_clr),
    .en(crc_en),
    .din(sh_bit),
    .crc_o(crc_byte)
  );

  always_comb begin
    state_d = state_q;
    extra_d = extra_q;
    load_sh = 1'b0;
    sh_din = data_q;
    sh_shift = 1'b0;
    crc_en = 1'b0;
    crc_clr = 1'b0;
    req_clr = 1'b0;
    tx_end_of_data_clr = 1'b0;
    take_hold = 1'b0;
    set_tx_holding_empty = 1'b0;
    set_arb = 1'b0;
    set_undr = 1'b0;
    case (state_q)
      vpwifr_st_idle: begin
        if (rx_eod_ok && any_req) begin
          crc_clr = 1'b1;
          state_d = vpwifr_st_norm;
        end
      end
      vpwifr_st_norm: begin
        // Losing the normalization bit is fine: the winner's bit syncs everyone
        if (sym_done) begin
          load_sh = 1'b1;
          take_hold = 1'b1;
          set_tx_holding_empty = ~single_q & ~tx_end_of_data_q;
          state_d = vpwifr_st_data;
        end
      end
      vpwifr_st_data: begin
        if (sym_done && sym_lost) begin
          set_arb = 1'b1;
          if (single_q) begin
            state_d = vpwifr_st_retry;
          end else begin
            req_clr = 1'b1;
            extra_d = 1'b0;
            state_d = sh_last ? vpwifr_st_extra : vpwifr_st_idle;
          end
        end else if (sym_done) begin
          crc_en = crc_q;
          sh_shift = ~sh_last;
          if (!sh_last) begin
            state_d = vpwifr_st_data;
          end else if (single_q) begin
            req_clr = 1'b1;
            state_d = vpwifr_st_idle;
          end else if (hold_q) begin
            load_sh = 1'b1;
            take_hold = 1'b1;
            set_tx_holding_empty = ~tx_end_of_data_q;
          end else if (tx_end_of_data_q && crc_q) begin
            load_sh = 1'b1;
            sh_din = crc_byte;
            state_d = vpwifr_st_crc;
          end else if (tx_end_of_data_q) begin
            state_d = vpwifr_st_eod;
          end else begin
            // Underrun: leave on a broken byte boundary so receivers flag it
            set_undr = 1'b1;
            req_clr = 1'b1;
            extra_d = 1'b0;
            state_d = vpwifr_st_extra;
          end
        end
      end
      vpwifr_st_crc: begin
        if (sym_done && sym_lost) begin
          set_arb = 1'b1;
          req_clr = 1'b1;
          extra_d = 1'b0;
          state_d = sh_last ? vpwifr_st_extra : vpwifr_st_idle;
        end else if (sym_done) begin
          sh_shift = ~sh_last;
          state_d = sh_last ? vpwifr_st_eod : vpwifr_st_crc;
        end
      end
      vpwifr_st_eod: begin
        if (sym_done) begin
          req_clr = 1'b1;
          state_d = vpwifr_st_echo;
        end
      end
      vpwifr_st_echo: begin
        if (rx_eod_ok) begin
          tx_end_of_data_clr = 1'b1;
          state_d = vpwifr_st_idle;
        end else if (rx_eof) begin
          state_d = vpwifr_st_idle;
        end
      end
      vpwifr_st_extra: begin
        if (sym_done) begin
          extra_d = 1'b1;
          state_d = extra_q ? vpwifr_st_idle : vpwifr_st_extra;
        end
      end
      vpwifr_st_retry: begin
        if (tx_end_of_data_q) begin
          req_clr = 1'b1;
          state_d = vpwifr_st_idle;
        end else if (rx_byte_valid && rx_byte == own_q) begin
          req_clr = 1'b1;
          state_d = vpwifr_st_idle;
        end else if (rx_byte_valid) begin
          load_sh = 1'b1;
          sh_din = own_q;
          state_d = vpwifr_st_data;
        end
      end
      default: begin
        state_d = vpwifr_st_idle;
      end
    endcase
    if (bus_error) begin
      req_clr = 1'b1;
      tx_end_of_data_clr = 1'b1;
      load_sh = 1'b0;
      take_hold = 1'b0;
      set_tx_holding_empty = 1'b0;
      state_d = vpwifr_st_idle;
    end
  end

  // Software writes win over hardware clears in the same cycle
  wire tx_end_of_data_kill_single = tx_end_of_data_q & req_q[2];
  assign req_d = wr_ctrl ? wr_req :
                 (req_clr ? `VPWIFR_REQ_RST :
                  (tx_end_of_data_kill_single ? {1'b0, req_q[1:0]} : req_q));
  assign tx_end_of_data_d = (wr_ctrl & pwdata[`VPWIFR_CTRL_TX_END_OF_DATA]) | (tx_end_of_data_q & ~tx_end_of_data_clr);

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      state_q <= vpwifr_st_idle;
      req_q <= `VPWIFR_REQ_RST;
      tx_end_of_data_q <= 1'b0;
      norm_bit_format_sel_q <= 1'b0;
      extra_q <= 1'b0;
    end else begin
      state_q <= state_d;
      req_q <= req_d;
      tx_end_of_data_q <= tx_end_of_data_d;
      extra_q <= extra_d;
      if (wr_ctrl) begin
        norm_bit_format_sel_q <= pwdata[`VPWIFR_CTRL_NORM_BIT_FORMAT_SEL];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      single_q <= 1'b0;
      crc_q <= 1'b0;
      post_eod_q <= 1'b0;
    end else begin
      if (state_q == vpwifr_st_idle && rx_eod_ok) begin
        single_q <= eff_single;
        crc_q <= eff_crc;
      end
      post_eod_q <= rx_eod_ok | (post_eod_q & ~rx_eof & ~bus_error);
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      data_q <= `VPWIFR_DATA_RST;
      own_q <= `VPWIFR_DATA_RST;
      hold_q <= 1'b0;
      tx_holding_empty_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      if (wr_data) begin
        data_q <= pwdata[7:0];
      end
      if (take_hold) begin
        own_q <= data_q;
      end
      hold_q <= wr_data | (hold_q & ~take_hold);
      // Cleared by a data write or by setting end-of-data
      tx_holding_empty_q <= set_tx_holding_empty | (tx_holding_empty_q & ~wr_data & ~tx_end_of_data_q);
      if (setup) begin
        prdata_q <= rd_mux;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      arb_q <= 1'b0;
      undr_q <= 1'b0;
      berr_q <= 1'b0;
    end else begin
      arb_q <= set_arb | (arb_q & ~(wr_stat & pwdata[`VPWIFR_STAT_ARB]));
      undr_q <= set_undr | (undr_q & ~(wr_stat & pwdata[`VPWIFR_STAT_UNDR]));
      berr_q <= bus_error | (berr_q & ~(wr_stat & pwdata[`VPWIFR_STAT_BERR]));
    end
  end
endmodule : vpwifr_tx

// ### dv/vpwifr_checker.sv
module vpwifr_checker
  import vpwifr_pkg::*;
(
  input wire logic mclk, // Module clock
  input wire logic nrst, // Reset, active low
  input wire logic rx_eod_ok, // EOD received
  input wire logic rx_byte_valid, // Byte seen on bus
  input wire logic bus_error, // Bus error
  input wire logic sym_valid, // Symbol on offer
  input wire vpwifr_pkg::vpwifr_sym_t sym_kind, // Kind of symbol
  input wire logic sym_bit, // Symbol bit
  input wire logic sym_done // Symbol ended
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  wire kind_eod = sym_kind == vpwifr_sym_eod;
  property p_norm_first;
    $rose(sym_valid) && $past(rx_eod_ok) |-> sym_kind == vpwifr_sym_norm;
  endproperty
  a_norm_first: assert property (p_norm_first) else $error("response not led by norm");
  property p_retry_data;
    $rose(sym_valid) && $past(rx_byte_valid) |-> sym_kind == vpwifr_sym_data;
  endproperty
  a_retry_data: assert property (p_retry_data) else $error("resend led by norm");
  property p_rise_cause;
    $rose(sym_valid) |-> $past(rx_eod_ok) || $past(rx_byte_valid);
  endproperty
  a_rise_cause: assert property (p_rise_cause) else $error("symbol out of turn");
  property p_hold;
    sym_valid && !sym_done && !bus_error |=> sym_valid && $stable(sym_kind) && $stable(sym_bit);
  endproperty
  a_hold: assert property (p_hold) else $error("symbol changed while offered");
  property p_eod_last;
    sym_valid && sym_done && kind_eod |=> !sym_valid [*3];
  endproperty
  a_eod_last: assert property (p_eod_last) else $error("symbol after end of data");
  property p_berr_stop;
    bus_error |=> !sym_valid;
  endproperty
  a_berr_stop: assert property (p_berr_stop) else $error("sending after bus error");
  property p_norm_data;
    sym_valid && sym_done && sym_kind == vpwifr_sym_norm && !bus_error
      |=> sym_valid && sym_kind == vpwifr_sym_data;
  endproperty
  a_norm_data: assert property (p_norm_data) else $error("no byte after norm");
  property p_eod_after;
    sym_valid && $rose(kind_eod) |-> $past(sym_valid) && $past(sym_kind) == vpwifr_sym_data;
  endproperty
  a_eod_after: assert property (p_eod_after) else $error("end of data not after bits");
  c_eod: cover property (sym_done && sym_valid && kind_eod);
  c_retry: cover property ($rose(sym_valid) && $past(rx_byte_valid));
  c_berr: cover property (bus_error && sym_valid);
endmodule : vpwifr_checker

bind vpwifr_tx vpwifr_checker vpwifr_checker_inst (.*);

// ### dv/vpwifr_bus_model.sv
module vpwifr_bus_model (
  input wire logic mclk, // Module clock
  input wire logic nrst, // Reset, active low
  input wire logic sym_valid, // Symbol on offer
  input wire logic slow, // Stretch every symbol
  input wire logic [7:0] lose_at, // Symbol number lost, zero for none
  output logic sym_done, // Symbol ended
  output logic sym_lost, // Arbitration lost on it
  output logic [7:0] n_sym // Symbols ended since reset
);
  logic [1:0] age_q;
  // A long symbol checks that the offer is held until the bus ends it
  wire end_now = sym_valid && !sym_done && age_q >= (slow ? 2'h3 : 2'h0);
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      sym_done <= 1'h0;
      sym_lost <= 1'h0;
      n_sym <= 8'h00;
      age_q <= 2'h0;
    end else begin
      sym_done <= end_now;
      sym_lost <= end_now && n_sym + 8'h01 == lose_at;
      n_sym <= n_sym + {7'h00, end_now};
      age_q <= (end_now || !sym_valid) ? 2'h0 : age_q + 2'h1;
    end
  end
endmodule : vpwifr_bus_model

// ### dv/vpwifr_tx_tb.sv
`include "vpwifr_cfg.svh"
module vpwifr_tx_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import vpwifr_pkg::*;
  logic mclk = 1'h0, nrst = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic rx_eod_ok = 1'h0, rx_eof = 1'h0, rx_byte_valid = 1'h0, bus_error = 1'h0;
  logic slow = 1'h0, pready, pslverr, sym_valid, sym_bit, sym_done, sym_lost, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h905c9899;
  logic [7:0] rx_byte = 8'h00, lose_at = 8'h00, n_sym;
  vpwifr_sym_t sym_kind;
  logic [2:0] seen[$], exp_q[$];
  logic [2:0] reqs[4] = '{3'h4, 3'h2, 3'h1, 3'h3};
  int n_fail = 0, tests_run = 0;
  vpwifr_tx vpwifr_tx_inst (.*);
  vpwifr_bus_model vpwifr_bus_model_inst (.*);
  initial forever #20 mclk = ~mclk;
  always @(posedge mclk) if (nrst && sym_valid && sym_done)
    seen.push_back({sym_kind, sym_kind != vpwifr_sym_eod && sym_bit});
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  function automatic logic [7:0] crc_step(input logic [7:0] c, input logic b);
    return {c[6:0], 1'h0} ^ ((c[7] ^ b) ? 8'h1d : 8'h00);
  endfunction : crc_step
  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run
  task automatic check(input string nm, input logic [31:0] sv, input logic [31:0] ev);
    tests_run++;
    if (sv !== ev) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, ev, sv);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge mclk);
    if (n == 20) check("apb ready", 0, 1);
  endtask : apb
  // One-cycle strobes: bit 0 eod, bit 1 eof, bit 2 byte seen, bit 3 bus error
  localparam logic [3:0] P_EOD = 4'h1;
  localparam logic [3:0] P_EOF = 4'h2;
  localparam logic [3:0] P_BYTE = 4'h4;
  localparam logic [3:0] P_ERR = 4'h8;
  task automatic pulse(input logic [3:0] m);
    rx_eod_ok <= m[0];
    rx_eof <= m[1];
    rx_byte_valid <= m[2];
    bus_error <= m[3];
    @(posedge mclk);
    rx_eod_ok <= 1'h0;
    rx_eof <= 1'h0;
    rx_byte_valid <= 1'h0;
    bus_error <= 1'h0;
    @(posedge mclk);
  endtask : pulse
  task automatic do_reset;
    nrst <= 1'h0;
    lose_at <= 8'h00;
    repeat (12) @(posedge mclk);
    nrst <= 1'h1;
    @(posedge mclk);
    seen.delete();
    exp_q.delete();
  endtask : do_reset
  task automatic settle(input int n);
    int k;
    for (k = 0; k < 600 && n_sym < n; k++) @(posedge mclk);
    if (k == 600) begin
      n_fail++;
      complete_run();
    end
    repeat (12) @(posedge mclk);
  endtask : settle
  task automatic cmp_syms;
    check("symbol count", seen.size(), exp_q.size());
    foreach (exp_q[i]) if (i < seen.size()) check("symbol", seen[i], exp_q[i]);
  endtask : cmp_syms
  task automatic run(input logic [2:0] req, input logic norm_bit_format_sel, input int nb, input logic und);
    logic [7:0] d, c;
    logic crc;
    int i, k;
    do_reset();
    seed = xs(seed);
    slow <= seed[0];
    d = seed[15:8];
    crc = req[1] && !req[2];
    c = 8'hff;
    if (req[2]) nb = 1;
    exp_q.push_back({vpwifr_sym_norm, crc ^ norm_bit_format_sel});
    apb(1'h1, `VPWIFR_OFS_DATA, {24'h0, d});
    apb(1'h1, `VPWIFR_OFS_CTRL, {28'h0, norm_bit_format_sel, req});
    pulse(P_EOD);
    for (i = 0; i < nb; i++) begin
      for (k = 7; k >= 0; k--) begin
        exp_q.push_back({vpwifr_sym_data, d[k]});
        c = crc_step(c, d[k]);
      end
      if (!req[2] && !und) begin
        for (k = 0; k < 40 && rd[0] !== 1'h1; k++) apb(1'h0, `VPWIFR_OFS_STAT, 32'h0);
        check("empty event", rd[0], 1);
        seed = xs(seed);
        d = seed[7:0];
        if (i == nb - 1) apb(1'h1, `VPWIFR_OFS_CTRL, {27'h1, norm_bit_format_sel, req});
        else apb(1'h1, `VPWIFR_OFS_DATA, {24'h0, d});
        rd = 32'h0;
      end
    end
    if (und) repeat (2) exp_q.push_back({vpwifr_sym_data, 1'h1});
    else if (crc) for (k = 7; k >= 0; k--) exp_q.push_back({vpwifr_sym_data, ~c[k]});
    if (!req[2] && !und) exp_q.push_back({vpwifr_sym_eod, 1'h0});
    settle(exp_q.size());
    cmp_syms();
    rx_byte <= exp_q[8][0] ? d : d;
    if (req[2]) pulse(P_BYTE);
    else if (!und) pulse(P_EOD);
    apb(1'h0, `VPWIFR_OFS_CTRL, 32'h0);
    check("ctrl after", rd, {28'h0, norm_bit_format_sel, 3'h0});
    apb(1'h0, `VPWIFR_OFS_STAT, 32'h0);
    check("underrun flag", rd[2], und);
    $display("test req %h norm_bit_format_sel %0d bytes %0d done", req, norm_bit_format_sel, nb);
  endtask : run
  task automatic lose_case(input logic [2:0] req, input logic [7:0] k);
    logic [7:0] d;
    do_reset();
    lose_at <= k;
    seed = xs(seed);
    d = seed[7:0];
    apb(1'h1, `VPWIFR_OFS_DATA, {24'h0, d});
    apb(1'h1, `VPWIFR_OFS_CTRL, {29'h0, req});
    pulse(P_EOD);
    settle(k);
    if (req[2]) begin
      check("single lost count", n_sym, k);
      seen.delete();
      for (int j = 7; j >= 0; j--) exp_q.push_back({vpwifr_sym_data, d[j]});
      rx_byte <= ~d;
      pulse(P_BYTE);
      settle(k + 8);
      cmp_syms();
      rx_byte <= d;
      pulse(P_BYTE);
    end else check("multi lost count", n_sym, k + (k == 8'h09 ? 2 : 0));
    apb(1'h0, `VPWIFR_OFS_CTRL, 32'h0);
    check("ctrl after loss", rd[2:0], 3'h0);
    apb(1'h0, `VPWIFR_OFS_STAT, 32'h0);
    check("arb flag", rd[1], 1);
    $display("test loss req %h bit %0d done", req, k);
  endtask : lose_case
  initial begin
    repeat (100000) @(posedge mclk);
    n_fail++;
    complete_run();
  end
  initial begin
    do_reset();
    apb(1'h0, `VPWIFR_OFS_CTRL, 32'h0);
    check("ctrl reset", rd, 0);
    apb(1'h0, `VPWIFR_OFS_STAT, 32'h0);
    check("state reset", rd[7:4], 0);
    apb(1'h1, `VPWIFR_OFS_CTRL, 32'h3);
    apb(1'h0, `VPWIFR_OFS_CTRL, 32'h0);
    check("raw readback", rd, 3);
    apb(1'h0, 12'h00c, 32'h0);
    check("unmapped", {err, rd[30:0]}, 32'h80000000);
    $display("test registers done");
    for (int i = 0; i < 8; i++) run(reqs[i % 4], i >= 4, i % 3 + 1, 1'h0);
    run(3'h1, 1'h0, 1, 1'h1);
    do_reset();
    pulse(P_EOD);
    apb(1'h1, `VPWIFR_OFS_CTRL, 32'h1);
    apb(1'h0, `VPWIFR_OFS_CTRL, 32'h0);
    check("late request", rd, 0);
    check("late symbols", n_sym, 0);
    pulse(P_EOF);
    $display("test late request done");
    lose_case(3'h4, 8'h03);
    lose_case(3'h4, 8'h09);
    lose_case(3'h2, 8'h09);
    lose_case(3'h2, 8'h04);
    lose_case(3'h1, 8'h09);
    do_reset();
    apb(1'h1, `VPWIFR_OFS_CTRL, 32'h4);
    pulse(P_EOD);
    repeat (3) @(posedge mclk);
    pulse(P_ERR);
    apb(1'h0, `VPWIFR_OFS_CTRL, 32'h0);
    check("ctrl after error", rd, 0);
    apb(1'h0, `VPWIFR_OFS_STAT, 32'h0);
    check("error flag", rd[3], 1);
    $display("test bus error done");
    complete_run();
  end
endmodule : vpwifr_tx_tb
